// >>> logic/crt_pkg.sv
// Constants for the capture/reload timer: register addresses, control bit
// positions, reset values and machine-cycle timing.
// Assumes a byte-wide special function register port in the core_clk domain.
`default_nettype none

package crt_pkg;

  // ****************************************
  // Register addresses
  // ****************************************
  localparam logic [7:0] ADDR_TIMER_CONTROL = 8'hc8;
  localparam logic [7:0] ADDR_CAPTURE_LOW   = 8'hca;
  localparam logic [7:0] ADDR_CAPTURE_HIGH  = 8'hcb;
  localparam logic [7:0] ADDR_COUNT_LOW     = 8'hcc;
  localparam logic [7:0] ADDR_COUNT_HIGH    = 8'hcd;

  // ****************************************
  // Control register bit positions
  // ****************************************
  localparam int BIT_OVERFLOW_FLAG       = 7;
  localparam int BIT_EXTERNAL_EVENT_FLAG = 6;
  localparam int BIT_SPARE_FLAG          = 5;
  localparam int BIT_SERIAL_CLOCK_SELECT = 4;
  localparam int BIT_EXT_TRIGGER_ENABLE  = 3;
  localparam int BIT_RUN_CONTROL         = 2;
  localparam int BIT_COUNT_SOURCE_SELECT = 1;
  localparam int BIT_CAPTURE_RELOAD_SEL  = 0;

  // ****************************************
  // Reset values and timing
  // ****************************************
  localparam logic [7:0]  RESET_TIMER_CONTROL = 8'h00;
  localparam logic [15:0] RESET_COUNT         = 16'h0000;
  localparam logic [15:0] RESET_CAPTURE       = 16'h0000;
  localparam logic [15:0] COUNT_MAX           = 16'hffff;
  localparam int          OSC_PER_MCYCLE      = 12;

  // Operating modes
  typedef enum logic [1:0] {
    CRT_OFF     = 2'b00,
    CRT_RELOAD  = 2'b01,
    CRT_CAPTURE = 2'b10,
    CRT_BAUD    = 2'b11
  } crt_mode_e;

endpackage

`default_nettype wire

// >>> logic/crt_timer.sv
// 16-bit capture/reload timer with its control register and SFR port.
// Assumes core_clk is the oscillator and all inputs are synchronous to it.
`default_nettype none

module crt_timer #(
  parameter int OSC_PER_MCYCLE = crt_pkg::OSC_PER_MCYCLE
) (
  // Clock and reset
  input  wire logic       core_clk,
  input  wire logic       srst,
  // Special function register port
  input  wire logic [7:0] sfr_addr,
  input  wire logic       sfr_wr,
  input  wire logic       sfr_rd,
  input  wire logic [7:0] sfr_wdata,
  output var  logic [7:0] sfr_rdata,
  // External pins
  input  wire logic       event_input,
  input  wire logic       trigger_input,
  // Serial clock path and interrupt
  input  wire logic       other_timer_ovf,
  output var  logic       serial_clk_pulse,
  output var  logic       timer_irq
);

  // ****************************************
  // Elaboration check
  // ****************************************
  if (OSC_PER_MCYCLE < 2 || OSC_PER_MCYCLE > 255) begin : g_bad_param
    $error("OSC_PER_MCYCLE out of range");
  end

  // ****************************************
  // State
  // ****************************************
  logic [7:0]  presc_r;
  logic        mtick_r;
  logic        ev_smp_r;
  logic        ev_prev_r;
  logic        tr_smp_r;
  logic        tr_prev_r;
  logic [15:0] count_r;
  logic [15:0] count_nxt;
  logic [15:0] capture_r;
  logic [15:0] capture_nxt;
  logic        overflow_flag_r;
  logic        external_event_flag_r;
  logic        spare_flag_r;
  logic        serial_clock_select_r;
  logic        external_trigger_enable_r;
  logic        run_control_r;
  logic        count_source_select_r;
  logic        capture_reload_select_r;
  logic        ovf_evt;
  logic        trig_act;

  // ****************************************
  // Machine cycle prescaler and pin sampling
  // ****************************************
  wire logic       presc_wrap = (presc_r == 8'(OSC_PER_MCYCLE - 1));

  // One tick every machine cycle
  always_ff @(posedge core_clk) begin
    if (srst) begin
      presc_r <= 8'h00;
      mtick_r <= 1'b0;
    end else begin
      presc_r <= presc_wrap ? 8'h00 : presc_r + 8'h01;
      mtick_r <= presc_wrap;
    end
  end

  // Sample once per machine cycle, compare with the previous sample
  always_ff @(posedge core_clk) begin
    if (srst) begin
      ev_smp_r  <= 1'b1;
      ev_prev_r <= 1'b1;
      tr_smp_r  <= 1'b1;
      tr_prev_r <= 1'b1;
    end else if (presc_wrap) begin
      ev_smp_r  <= event_input;
      ev_prev_r <= ev_smp_r;
      tr_smp_r  <= trigger_input;
      tr_prev_r <= tr_smp_r;
    end
  end

  // Edge only counts once, on the machine-cycle tick after both samples
  wire logic ev_fall = mtick_r & ev_prev_r & ~ev_smp_r;
  wire logic tr_fall = mtick_r & tr_prev_r & ~tr_smp_r;

  // ****************************************
  // Mode decode
  // ****************************************
  // Serial clocking overrides capture select
  wire crt_pkg::crt_mode_e mode =
      !run_control_r          ? crt_pkg::CRT_OFF :
      serial_clock_select_r   ? crt_pkg::CRT_BAUD :
      capture_reload_select_r ? crt_pkg::CRT_CAPTURE : crt_pkg::CRT_RELOAD;

  // Count source: machine cycles or event pin edges
  wire logic cnt_step = (mode != crt_pkg::CRT_OFF) &
                        (count_source_select_r ? ev_fall : mtick_r);
  wire logic cnt_ovf  = cnt_step & (count_r == crt_pkg::COUNT_MAX);

  // Trigger ignored while clocking the serial port
  wire logic trig_ok  = external_trigger_enable_r & (mode != crt_pkg::CRT_OFF) & (mode != crt_pkg::CRT_BAUD);

  // ****************************************
  // Register decode
  // ****************************************
  wire logic wr_ctrl = sfr_wr & (sfr_addr == crt_pkg::ADDR_TIMER_CONTROL);
  wire logic wr_capl = sfr_wr & (sfr_addr == crt_pkg::ADDR_CAPTURE_LOW);
  wire logic wr_caph = sfr_wr & (sfr_addr == crt_pkg::ADDR_CAPTURE_HIGH);
  wire logic wr_cntl = sfr_wr & (sfr_addr == crt_pkg::ADDR_COUNT_LOW);
  wire logic wr_cnth = sfr_wr & (sfr_addr == crt_pkg::ADDR_COUNT_HIGH);

  wire logic [7:0] ctrl_rd = {overflow_flag_r, external_event_flag_r, spare_flag_r,
                              serial_clock_select_r, external_trigger_enable_r,
                              run_control_r, count_source_select_r, capture_reload_select_r};

  wire logic [7:0] rd_mux =
      (sfr_addr == crt_pkg::ADDR_TIMER_CONTROL) ? ctrl_rd :
      (sfr_addr == crt_pkg::ADDR_CAPTURE_LOW)   ? capture_r[7:0] :
      (sfr_addr == crt_pkg::ADDR_CAPTURE_HIGH)  ? capture_r[15:8] :
      (sfr_addr == crt_pkg::ADDR_COUNT_LOW)     ? count_r[7:0] :
      (sfr_addr == crt_pkg::ADDR_COUNT_HIGH)    ? count_r[15:8] : 8'h00;

  // ****************************************
  // Counter and capture pair next state
  // ****************************************
  // Mode decides what an overflow and a trigger edge do
  always_comb begin
    count_nxt   = cnt_step ? count_r + 16'h0001 : count_r;
    capture_nxt = capture_r;
    ovf_evt     = 1'b0;
    trig_act    = 1'b0;
    case (mode)
      crt_pkg::CRT_RELOAD: begin
        ovf_evt = cnt_ovf;
        if (cnt_ovf) begin
          count_nxt = capture_r;
        end
        if (trig_ok && tr_fall) begin
          count_nxt = capture_r;
          trig_act  = 1'b1;
        end
      end
      crt_pkg::CRT_CAPTURE: begin
        ovf_evt = cnt_ovf;
        if (trig_ok && tr_fall) begin
          capture_nxt = count_r;
          trig_act    = 1'b1;
        end
      end
      crt_pkg::CRT_BAUD: begin
        if (cnt_ovf) begin
          count_nxt = capture_r;
        end
      end
      default: begin
        count_nxt = count_r;
      end
    endcase
    // Software writes win over counting
    if (wr_cntl) begin
      count_nxt[7:0] = sfr_wdata;
    end
    if (wr_cnth) begin
      count_nxt[15:8] = sfr_wdata;
    end
    if (wr_capl) begin
      capture_nxt[7:0] = sfr_wdata;
    end
    if (wr_caph) begin
      capture_nxt[15:8] = sfr_wdata;
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      count_r   <= crt_pkg::RESET_COUNT;
      capture_r <= crt_pkg::RESET_CAPTURE;
    end else begin
      count_r   <= count_nxt;
      capture_r <= capture_nxt;
    end
  end

  // ****************************************
  // Control register
  // ****************************************
  // Flags: hardware set wins over a software clear; writing 1 cannot set them
  wire logic ovf_flag_nxt = ovf_evt |
      (overflow_flag_r & ~(wr_ctrl & ~sfr_wdata[crt_pkg::BIT_OVERFLOW_FLAG]));
  wire logic ext_flag_nxt = trig_act |
      (external_event_flag_r & ~(wr_ctrl & ~sfr_wdata[crt_pkg::BIT_EXTERNAL_EVENT_FLAG]));

  always_ff @(posedge core_clk) begin
    if (srst) begin
      {overflow_flag_r, external_event_flag_r, spare_flag_r, serial_clock_select_r,
       external_trigger_enable_r, run_control_r, count_source_select_r,
       capture_reload_select_r} <= crt_pkg::RESET_TIMER_CONTROL;
    end else begin
      overflow_flag_r       <= ovf_flag_nxt;
      external_event_flag_r <= ext_flag_nxt;
      if (wr_ctrl) begin
        spare_flag_r              <= sfr_wdata[crt_pkg::BIT_SPARE_FLAG];
        serial_clock_select_r     <= sfr_wdata[crt_pkg::BIT_SERIAL_CLOCK_SELECT];
        external_trigger_enable_r <= sfr_wdata[crt_pkg::BIT_EXT_TRIGGER_ENABLE];
        run_control_r             <= sfr_wdata[crt_pkg::BIT_RUN_CONTROL];
        count_source_select_r     <= sfr_wdata[crt_pkg::BIT_COUNT_SOURCE_SELECT];
        capture_reload_select_r   <= sfr_wdata[crt_pkg::BIT_CAPTURE_RELOAD_SEL];
      end
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  // All outputs registered; read data lags the read strobe by one cycle
  always_ff @(posedge core_clk) begin
    if (srst) begin
      sfr_rdata        <= 8'h00;
      serial_clk_pulse <= 1'b0;
      timer_irq        <= 1'b0;
    end else begin
      sfr_rdata        <= sfr_rd ? rd_mux : 8'h00;
      serial_clk_pulse <= serial_clock_select_r ? (mode == crt_pkg::CRT_BAUD) & cnt_ovf
                                                : other_timer_ovf;
      timer_irq        <= overflow_flag_r | external_event_flag_r;
    end
  end

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (srst);

  a_ovf_flag_set: assert property (ovf_evt |=> overflow_flag_r)
    else $error("overflow did not set flag");

  a_capture_copy: assert property (
    (mode == crt_pkg::CRT_CAPTURE && trig_ok && tr_fall && !wr_capl && !wr_caph)
    |=> capture_r == $past(count_r) && external_event_flag_r)
    else $error("capture did not copy count");

  a_reload_ovf: assert property (
    (mode == crt_pkg::CRT_RELOAD && cnt_ovf && !wr_cntl && !wr_cnth)
    |=> count_r == $past(capture_r) && overflow_flag_r)
    else $error("overflow did not reload");

  a_trig_reload: assert property (
    (mode == crt_pkg::CRT_RELOAD && trig_ok && tr_fall && !wr_cntl && !wr_cnth)
    |=> count_r == $past(capture_r) && external_event_flag_r)
    else $error("trigger did not reload");

  a_ovf_not_baud: assert property (
    (serial_clock_select_r && !overflow_flag_r) |=> !overflow_flag_r)
    else $error("overflow flag set while serial clocking");

  a_irq_follows: assert property (
    external_event_flag_r |=> timer_irq ##1 (timer_irq || !$past(external_event_flag_r)))
    else $error("event flag did not request interrupt");

  a_serial_src: assert property (
    !serial_clock_select_r |=> serial_clk_pulse == $past(other_timer_ovf))
    else $error("serial clock not from other timer");

  a_trig_ignored: assert property (
    (!external_trigger_enable_r && !external_event_flag_r) |=> !external_event_flag_r)
    else $error("trigger acted while disabled");

  a_run_off: assert property (
    (!run_control_r && !wr_cntl && !wr_cnth) |=> $stable(count_r))
    else $error("count moved while stopped");

  a_timer_rate: assert property (
    (mode == crt_pkg::CRT_CAPTURE && !count_source_select_r && !mtick_r && !wr_cntl && !wr_cnth)
    |=> $stable(count_r))
    else $error("timer counted off machine tick");

  a_spare_rw: assert property (wr_ctrl |=> spare_flag_r == $past(sfr_wdata[5]))
    else $error("spare flag not written");

  // Cycles since the last tick, counted apart from the prescaler so a wrong wrap shows
  logic [7:0] mc_gap_r;

  always_ff @(posedge core_clk) begin
    if (srst) begin
      mc_gap_r <= 8'h00;
    end else begin
      mc_gap_r <= mtick_r ? 8'h01 : mc_gap_r + 8'h01;
    end
  end

  a_mcycle_len: assert property ((mtick_r && mc_gap_r == 8'(OSC_PER_MCYCLE)) ||
                                 (!mtick_r && mc_gap_r < 8'(OSC_PER_MCYCLE)))
    else $error("machine cycle length wrong");

  c_capture: cover property (trig_act && mode == crt_pkg::CRT_CAPTURE);
  c_reload:  cover property (ovf_evt && mode == crt_pkg::CRT_RELOAD);
  c_baud:    cover property (serial_clk_pulse && serial_clock_select_r);
  c_clear:   cover property (wr_ctrl && overflow_flag_r ##1 !overflow_flag_r);

endmodule

`default_nettype wire

// >>> sim/crt_pin_model.sv
// Pin-side partner: drives the external event and trigger pins.
// Assumes the pins idle high on their pull-ups and one pulse per fire request.
`default_nettype none

module crt_pin_model #(
  parameter int MC = 12
) (
  // Clock and reset
  input  wire logic core_clk,
  input  wire logic srst,
  // Requests from the bench
  input  wire logic fire_trig,
  input  wire logic fire_evt,
  // Pins
  output var  logic trigger_input,
  output var  logic event_input
);
  timeunit 1ns;
  timeprecision 1ns;

  int trig_cnt;
  int evt_cnt;

  // Low for two machine cycles so the sampler always sees it
  always_ff @(posedge core_clk) begin
    if (srst) begin
      trig_cnt <= 0;
      evt_cnt  <= 0;
    end else begin
      trig_cnt <= fire_trig ? 2 * MC : (trig_cnt > 0 ? trig_cnt - 1 : 0);
      evt_cnt  <= fire_evt ? 2 * MC : (evt_cnt > 0 ? evt_cnt - 1 : 0);
    end
  end

  // Released pins return high
  assign trigger_input = (trig_cnt == 0);
  assign event_input   = (evt_cnt == 0);
endmodule

`default_nettype wire

// >>> sim/capture_reload_timer_tb.sv
// Self-checking bench for the capture/reload timer.
// Assumes crt_pkg, crt_timer and crt_pin_model are compiled first.
`default_nettype none
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin err_count++; \
  $display("wrong value at %0t got %h exp %h", $time, g, e); end end

module capture_reload_timer_tb;
  timeunit 1ns;
  timeprecision 1ns;

  // ****************************************
  // Setup
  // ****************************************
  // Short machine cycle keeps the run brief
  localparam int         MC = 4;
  localparam logic [7:0] CT = crt_pkg::ADDR_TIMER_CONTROL;
  localparam logic [7:0] CL = crt_pkg::ADDR_CAPTURE_LOW;
  localparam logic [7:0] CH = crt_pkg::ADDR_CAPTURE_HIGH;
  localparam logic [7:0] NL = crt_pkg::ADDR_COUNT_LOW;
  localparam logic [7:0] NH = crt_pkg::ADDR_COUNT_HIGH;

  logic       core_clk        = 1'b0;
  logic       srst            = 1'b1;
  logic [7:0] sfr_addr        = 8'h00;
  logic       sfr_wr          = 1'b0;
  logic       sfr_rd          = 1'b0;
  logic [7:0] sfr_wdata       = 8'h00;
  logic       other_timer_ovf = 1'b0;
  logic       fire_trig       = 1'b0;
  logic       fire_evt        = 1'b0;
  logic [7:0] sfr_rdata;
  logic       event_input;
  logic       trigger_input;
  logic       serial_clk_pulse;
  logic       timer_irq;
  int         err_count       = 0;
  int         checks_done     = 0;
  int         seed            = 32'hfe6b;
  logic [7:0] rf [3]          = '{8'h05, 8'h1c, 8'h09};

  always #10 core_clk = ~core_clk;

  crt_timer #(.OSC_PER_MCYCLE(MC)) uut (
    .core_clk(core_clk), .srst(srst), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
    .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
    .event_input(event_input), .trigger_input(trigger_input),
    .other_timer_ovf(other_timer_ovf), .serial_clk_pulse(serial_clk_pulse),
    .timer_irq(timer_irq));

  crt_pin_model #(.MC(MC)) pins (
    .core_clk(core_clk), .srst(srst), .fire_trig(fire_trig), .fire_evt(fire_evt),
    .trigger_input(trigger_input), .event_input(event_input));

  // ****************************************
  // Tasks
  // ****************************************
  task automatic final_report();
    if (err_count == 0 && checks_done > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    sfr_addr  <= a;
    sfr_wdata <= d;
    sfr_wr    <= 1'b1;
    @(posedge core_clk);
    sfr_wr <= 1'b0;
  endtask

  // Read data stands only in the cycle after the taking edge, then drops to 0
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge core_clk);
    sfr_addr <= a;
    sfr_rd   <= 1'b1;
    @(posedge core_clk);
    sfr_rd <= 1'b0;
    #1 d = sfr_rdata;
  endtask

  task automatic rchk(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] d;
    rd(a, d);
    `CHK(d, e)
  endtask

  // Bounded wait on the request or the serial pulse
  task automatic wait_for(input bit ser, input logic v);
    int n;
    n = 0;
    while (((ser ? serial_clk_pulse : timer_irq) !== v) && n < 600) begin
      @(posedge core_clk);
      #1 n++;
    end
    if (n >= 600) begin
      err_count++;
      final_report();
    end
  endtask

  // One pin pulse, then time for recognition to finish
  task automatic fire(input bit t);
    @(posedge core_clk);
    fire_trig <= t;
    fire_evt  <= !t;
    @(posedge core_clk);
    fire_trig <= 1'b0;
    fire_evt  <= 1'b0;
    repeat (5 * MC) @(posedge core_clk);
  endtask

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    logic [7:0] a;
    logic [7:0] b;
    int n;
    repeat (6) @(posedge core_clk);
    srst <= 1'b0;
    rchk(CT, crt_pkg::RESET_TIMER_CONTROL);
    rchk(8'hc9, 8'h00);
    wr(CT, 8'he0);
    rchk(CT, 8'h20);
    // Stopped, then running: read edges exactly ten machine cycles apart
    for (int r = 0; r < 2; r++) begin
      wr(NL, 8'h00);
      wr(CT, r ? 8'h04 : 8'h00);
      rd(NL, a);
      repeat (10 * MC - 2) @(posedge core_clk);
      rd(NL, b);
      `CHK(b - a, r ? 8'h0a : 8'h00)
    end
    // Overflow in reload and in capture mode
    for (int m = 0; m < 2; m++) begin
      a = 8'h20 + 8'($random(seed) & 32'h7f);
      wr(CL, 8'h00);
      wr(CH, a);
      wr(NL, 8'hf8);
      wr(NH, 8'hff);
      wr(CT, 8'h04 | 8'(m));
      wait_for(1'b0, 1'b1);
      rchk(NH, m ? 8'h00 : a);
      rchk(CT, 8'h84 | 8'(m));
      wr(CT, 8'h00);
      wait_for(1'b0, 1'b0);
    end
    // Trigger edge: reload, then capture
    for (int m = 0; m < 2; m++) begin
      a = 8'h20 + 8'($random(seed) & 32'h3f);
      wr(CH, a);
      wr(NL, 8'h00);
      wr(NH, a + 8'h60);
      wr(CT, 8'h0c | 8'(m));
      fire(1'b1);
      rchk(m ? CH : NH, m ? a + 8'h60 : a);
      rchk(CT, 8'h4c | 8'(m));
      wr(CT, 8'h00);
      wait_for(1'b0, 1'b0);
    end
    // Trigger edges that must be ignored; count high differs so a stray capture shows
    wr(CH, 8'h00);
    wr(NH, 8'h3c);
    foreach (rf[i]) begin
      wr(CT, rf[i]);
      fire(1'b1);
      rchk(CT, rf[i]);
      rchk(CH, 8'h00);
    end
    // Serial clocking: repeated pulses prove the forced reload
    wr(CL, 8'hf0);
    wr(CH, 8'hff);
    wr(NL, 8'hf0);
    wr(NH, 8'hff);
    wr(CT, 8'h15);
    wait_for(1'b1, 1'b1);
    wait_for(1'b1, 1'b0);
    wait_for(1'b1, 1'b1);
    rchk(CT, 8'h15);
    `CHK(timer_irq, 1'b0)
    wr(CT, 8'h00);
    @(posedge core_clk);
    other_timer_ovf <= 1'b1;
    @(posedge core_clk);
    other_timer_ovf <= 1'b0;
    // The passed-on pulse stands for exactly the cycle after the taking edge
    #1 `CHK(serial_clk_pulse, 1'b1)
    @(posedge core_clk);
    #1 `CHK(serial_clk_pulse, 1'b0)
    // Event counting
    n = 1 + ($random(seed) & 3);
    wr(NL, 8'h00);
    wr(NH, 8'h00);
    wr(CT, 8'h06);
    repeat (n) fire(1'b0);
    rchk(NL, 8'(n));
    final_report();
  end
endmodule

`default_nettype wire
